// file: verilog/dac_register_nvm_control.sv
module dac_register_nvm_control (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  input  wire logic [7:0]                     addr,
  input  wire logic [15:0]                    wdata,
  input  wire logic                           frame_end,
  input  wire logic [15:0]                    nvm_rdata,
  output logic      [15:0]                    rdata,
  output logic      [dac_ctrl_pkg::CODE_BITS-1:0] out_code,
  output logic      [1:0]                     output_power_down_mode,
  output logic                                ref_enable,
  output logic      [3:0]                     gain_halves,
  output logic      [1:0]                     waveform_select,
  output logic                                waveform_launch,
  output logic                                store_busy,
  output logic                                update_pending,
  output logic                                user_image_check_fail,
  output logic                                factory_image_check_fail,
  output logic      [2:0]                     nvm_addr,
  output logic                                nvm_we,
  output logic      [15:0]                    nvm_wdata
);
  import dac_ctrl_pkg::*;

  typedef struct packed {
    fsm_type             st;
    logic [2:0]          idx;
    logic [7:0][15:0]    img;
    logic [15:0]         code;
    logic [15:0]         mhigh;
    logic [15:0]         mlow;
    logic [15:0]         setup;
    logic                launch;
    logic                store_req;
    logic                reload_req;
    logic                pending;
    logic                busy;
    logic                user_fail;
    logic                fact_fail;
    logic [CODE_BITS-1:0] out_code;
    logic [3:0]          gain;
    logic [15:0]         rdata;
    logic [2:0]          nvm_addr;
    logic                nvm_we;
    logic [15:0]         nvm_wdata;
  } state_type;

  state_type s_q;
  state_type s_d;
  logic [USER_WORDS-1:0][15:0] save_w;
  logic [9:0]                  save_crc;
  logic [9:0]                  load_crc;
  logic [9:0]                  fact_crc;

  // Serial check-word step over one 16-bit word, msb first
  function automatic logic [9:0] crc_word(input logic [9:0] c, input logic [15:0] w);
    logic [9:0] r;
    logic       fb;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      fb = r[9] ^ w[i];
      r  = {r[8:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // Check word over the user part of an image
  function automatic logic [9:0] crc_user(input logic [USER_WORDS-1:0][15:0] w);
    logic [9:0] r;
    r = CRC_SEED;
    for (int k = 0; k < USER_WORDS; k++) begin
      r = crc_word(r, w[k]);
    end
    return r;
  endfunction

  // Gain code to half steps
  function automatic logic [3:0] gain_decode(input logic [1:0] g);
    case (g)
      GAIN_1P5: gain_decode = HALVES_1P5;
      GAIN_2:   gain_decode = HALVES_2;
      GAIN_3:   gain_decode = HALVES_3;
      default:  gain_decode = HALVES_4;
    endcase
  endfunction

  // Power-on state: factory values, alarms clear, reload from the image
  function automatic state_type reset_value();
    state_type r;
    r          = '0;
    r.st       = LOADING;
    r.code     = DEFAULT_CODE;
    r.mhigh    = DEFAULT_MARGIN;
    r.mlow     = DEFAULT_MARGIN;
    r.setup    = DEFAULT_SETUP;
    r.gain     = gain_decode(DEFAULT_SETUP[GAIN_LSB +: 2]);
    r.busy     = 1'b1;
    return r;
  endfunction

  // Words written by a store; margins keep only their upper eight bits
  always_comb begin
    save_w[0] = s_q.setup & SETUP_STORE;
    save_w[1] = {7'h00, s_q.launch, 8'h00};
    save_w[2] = s_q.code & CODE_MASK;
    save_w[3] = s_q.mhigh & MARGIN_STORE;
    save_w[4] = s_q.mlow & MARGIN_STORE;
    save_crc  = crc_user(save_w);
  end

  // Check words recomputed over the image read back
  always_comb begin
    load_crc = crc_user(s_q.img[USER_WORDS-1:0]);
    fact_crc = crc_word(CRC_SEED, s_q.img[6]);
  end

  // Next state
  always_comb begin
    s_d           = s_q;
    s_d.nvm_we    = 1'b0;
    s_d.nvm_wdata = 16'h0000;
    case (s_q.st)
      // Image word at nvm_addr is valid while nvm_addr stands
      LOADING: begin
        s_d.img[s_q.nvm_addr] = nvm_rdata;
        if (s_q.nvm_addr == NVM_LAST) begin
          s_d.st       = CHECKING;
          s_d.nvm_addr = 3'h0;
        end else begin
          s_d.nvm_addr = s_q.nvm_addr + 3'h1;
        end
      end
      CHECKING: begin
        if (load_crc == s_q.img[NVM_USER_CRC][9:0]) begin
          s_d.setup  = s_q.img[0] & SETUP_STORE;
          s_d.launch = s_q.img[1][LAUNCH_BIT];
          s_d.code   = s_q.img[2] & CODE_MASK;
          s_d.mhigh  = s_q.img[3] & MARGIN_STORE;
          s_d.mlow   = s_q.img[4] & MARGIN_STORE;
        end else begin
          // Corrupt user image: keep factory values, registers stay usable
          s_d.user_fail = 1'b1;
          s_d.setup     = DEFAULT_SETUP;
          s_d.launch    = 1'b0;
          s_d.code      = DEFAULT_CODE;
          s_d.mhigh     = DEFAULT_MARGIN;
          s_d.mlow      = DEFAULT_MARGIN;
        end
        if (fact_crc != s_q.img[NVM_LAST][9:0]) begin
          s_d.fact_fail = 1'b1;
        end
        s_d.out_code   = s_d.code[CODE_LSB +: CODE_BITS];
        s_d.pending    = 1'b0;
        s_d.reload_req = 1'b0;
        s_d.st         = IDLE;
      end
      STORING: begin
        s_d.nvm_we   = 1'b1;
        s_d.nvm_addr = s_q.idx;
        s_d.nvm_wdata = (s_q.idx == NVM_USER_CRC) ? {6'h00, save_crc} : save_w[s_q.idx];
        if (s_q.idx == NVM_USER_CRC) begin
          s_d.st        = IDLE;
          s_d.store_req = 1'b0;
        end else begin
          s_d.idx = s_q.idx + 3'h1;
        end
      end
      IDLE: begin
        // Writes are taken only while no store or reload runs
        if (wr_en && !s_q.busy) begin
          case (addr)
            ADDR_OUTPUT_CODE: begin
              s_d.code    = wdata & CODE_MASK;
              s_d.pending = 1'b1;
            end
            ADDR_UPPER_MARGIN: s_d.mhigh = wdata & CODE_MASK;
            ADDR_LOWER_MARGIN: s_d.mlow  = wdata & CODE_MASK;
            ADDR_OUTPUT_SETUP: s_d.setup = wdata;
            ADDR_TRIGGERS: begin
              s_d.launch = wdata[LAUNCH_BIT];
              if (wdata[SOFT_RESET_LSB +: 4] == SOFT_RESET_CODE) begin
                s_d = reset_value();
              end else if (wdata[STORE_BIT]) begin
                s_d.st        = STORING;
                s_d.idx       = 3'h0;
                s_d.store_req = 1'b1;
              end else if (wdata[RELOAD_BIT]) begin
                s_d.st         = LOADING;
                s_d.nvm_addr   = 3'h0;
                s_d.reload_req = 1'b1;
              end
            end
            default: ;
          endcase
        end
        // Output takes a written code only at frame end, so a half-written code never shows
        if (frame_end && s_d.pending && s_d.st == IDLE) begin
          s_d.out_code = s_d.code[CODE_LSB +: CODE_BITS];
          s_d.pending  = 1'b0;
        end
      end
      default: s_d = reset_value();
    endcase
    // Read data; output code reads are undefined while busy by contract
    if (rd_en) begin
      case (addr)
        ADDR_OUTPUT_CODE:  s_d.rdata = s_q.code;
        ADDR_UPPER_MARGIN: s_d.rdata = s_q.mhigh;
        ADDR_LOWER_MARGIN: s_d.rdata = s_q.mlow;
        ADDR_OUTPUT_SETUP: s_d.rdata = s_q.setup;
        ADDR_TRIGGERS: begin
          s_d.rdata = {7'h00, s_q.launch, 2'h0, s_q.store_req, s_q.reload_req, 4'h0};
        end
        ADDR_STATUS: begin
          s_d.rdata                 = 16'h0000;
          s_d.rdata[ST_PENDING_BIT] = s_q.pending;
          s_d.rdata[ST_BUSY_BIT]    = s_q.busy;
          s_d.rdata[ST_USER_BIT]    = s_q.user_fail;
          s_d.rdata[ST_FACTORY_BIT] = s_q.fact_fail;
        end
        default: s_d.rdata = 16'h0000;
      endcase
    end
    s_d.gain = gain_decode(s_d.setup[GAIN_LSB +: 2]);
    // Busy covers the trailing write still in flight to the memory
    s_d.busy = (s_d.st != IDLE) || s_d.nvm_we;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= reset_value();
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign rdata                    = s_q.rdata;
  assign out_code                 = s_q.out_code;
  assign output_power_down_mode   = s_q.setup[PDN_LSB +: 2];
  assign ref_enable               = s_q.setup[REF_EN_BIT];
  assign gain_halves              = s_q.gain;
  assign waveform_select          = s_q.setup[WAVE_LSB +: 2];
  assign waveform_launch          = s_q.launch;
  assign store_busy               = s_q.busy;
  assign update_pending           = s_q.pending;
  assign user_image_check_fail    = s_q.user_fail;
  assign factory_image_check_fail = s_q.fact_fail;
  assign nvm_addr                 = s_q.nvm_addr;
  assign nvm_we                   = s_q.nvm_we;
  assign nvm_wdata                = s_q.nvm_wdata;

  // Checks on the state register
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_busy_blocks: assert property (
    // The check cycle of a reload loads these registers itself, so it is left out
    store_busy && wr_en && s_q.st != CHECKING
    |=> $stable(s_q.setup) && $stable(s_q.mhigh) && $stable(s_q.mlow))
    else $error("register changed during busy");

  a_frame_apply: assert property (
    !store_busy && wr_en && addr == ADDR_OUTPUT_CODE && frame_end
    |=> out_code == $past(wdata[CODE_LSB +: CODE_BITS]) && !update_pending)
    else $error("output not applied at frame end");

  a_no_early_out: assert property (
    !frame_end && !store_busy && s_q.st == IDLE
    && !(wr_en && addr == ADDR_TRIGGERS && wdata[SOFT_RESET_LSB +: 4] == SOFT_RESET_CODE)
    |=> $stable(out_code))
    else $error("output changed outside frame end");

  a_pending_set: assert property (
    !store_busy && wr_en && addr == ADDR_OUTPUT_CODE && !frame_end |=> update_pending)
    else $error("pending not raised");

  a_store_ends: assert property (
    s_q.st == IDLE && s_d.st == STORING |=> store_busy [*7] ##1 !store_busy)
    else $error("store busy length wrong");

  a_reload_clear: assert property (
    $fell(store_busy) |-> !s_q.reload_req && !s_q.store_req)
    else $error("request bit not cleared");

  a_margin_word: assert property (
    nvm_we && (nvm_addr == 3'h3 || nvm_addr == 3'h4) |-> (nvm_wdata & ~MARGIN_STORE) == 16'h0000)
    else $error("margin low bits stored");

  a_alarm_sticky: assert property (
    user_image_check_fail && !(wr_en && addr == ADDR_TRIGGERS)
    |=> user_image_check_fail)
    else $error("alarm dropped");

  a_fail_defaults: assert property (
    $rose(user_image_check_fail) |-> s_q.setup == DEFAULT_SETUP && s_q.code == DEFAULT_CODE)
    else $error("defaults not loaded");

  a_gain_map: assert property (
    s_q.setup[GAIN_LSB +: 2] == GAIN_3 |-> gain_halves == HALVES_3)
    else $error("gain decode wrong");

  c_store_done: cover property ($fell(store_busy) ##1 s_q.st == IDLE);
  c_user_fail:  cover property ($rose(user_image_check_fail));
  c_frame_out:  cover property (update_pending ##1 !update_pending);
  c_soft_reset: cover property (wr_en && addr == ADDR_TRIGGERS && wdata[3:0] == SOFT_RESET_CODE);

endmodule // dac_register_nvm_control

// file: inc/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_OUTPUT_CODE  = 8'h10;
  localparam logic [7:0] ADDR_UPPER_MARGIN = 8'h25;
  localparam logic [7:0] ADDR_LOWER_MARGIN = 8'h26;
  localparam logic [7:0] ADDR_STATUS       = 8'hD0;
  localparam logic [7:0] ADDR_OUTPUT_SETUP = 8'hD1;
  localparam logic [7:0] ADDR_TRIGGERS     = 8'hD3;

  // Field layout
  localparam int CODE_BITS       = 10;
  localparam int CODE_LSB        = 2;
  localparam int GAIN_LSB        = 0;
  localparam int REF_EN_BIT      = 2;
  localparam int PDN_LSB         = 3;
  localparam int WAVE_LSB        = 14;
  localparam int SOFT_RESET_LSB  = 0;
  localparam int RELOAD_BIT      = 4;
  localparam int STORE_BIT       = 5;
  localparam int LAUNCH_BIT      = 8;
  localparam int ST_PENDING_BIT  = 0;
  localparam int ST_BUSY_BIT     = 2;
  localparam int ST_USER_BIT     = 12;
  localparam int ST_FACTORY_BIT  = 13;

  // Writable and storable masks
  localparam logic [15:0] CODE_MASK        = 16'h0FFC;
  localparam logic [15:0] MARGIN_STORE     = 16'h0FF0;
  localparam logic [15:0] SETUP_STORE      = 16'hEFFF;
  localparam logic [15:0] LAUNCH_MASK      = 16'h0100;
  localparam logic [3:0]  SOFT_RESET_CODE  = 4'hA;

  // Factory defaults: Hi-Z startup, no slew, supply reference, gain 1.5x
  localparam logic [15:0] DEFAULT_SETUP    = 16'h01F8;
  localparam logic [15:0] DEFAULT_CODE     = 16'h0000;
  localparam logic [15:0] DEFAULT_MARGIN   = 16'h0000;
  localparam logic [1:0]  PDN_HIZ          = 2'h3;

  // Gain field encoding, expressed as gain in half steps
  localparam logic [1:0]  GAIN_1P5 = 2'h0;
  localparam logic [1:0]  GAIN_2   = 2'h1;
  localparam logic [1:0]  GAIN_3   = 2'h2;
  localparam logic [3:0]  HALVES_1P5 = 4'h3;
  localparam logic [3:0]  HALVES_2   = 4'h4;
  localparam logic [3:0]  HALVES_3   = 4'h6;
  localparam logic [3:0]  HALVES_4   = 4'h8;

  // Nonvolatile image layout: five user words, user check, factory word, factory check
  localparam int          USER_WORDS     = 5;
  localparam logic [2:0]  NVM_USER_CRC   = 3'h5;
  localparam logic [2:0]  NVM_LAST       = 3'h7;
  localparam logic [9:0]  CRC_POLY       = 10'h233;
  localparam logic [9:0]  CRC_SEED       = 10'h000;

  typedef enum logic [1:0] {LOADING, CHECKING, IDLE, STORING} fsm_type;

endpackage

// file: tb/nvm_image_model.sv
module nvm_image_model (
  input  wire logic        clk,
  input  wire logic [2:0]  nvm_addr,
  input  wire logic        nvm_we,
  input  wire logic [15:0] nvm_wdata,
  output logic      [15:0] nvm_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] mem [8];

  // Sense path is combinational, so data follows the address at once
  assign nvm_rdata = mem[nvm_addr];

  // One word is programmed per strobe; no erase model is needed here
  always @(posedge clk) begin
    if (nvm_we) begin
      mem[nvm_addr] <= nvm_wdata;
    end
  end
endmodule // nvm_image_model

// file: tb/dac_register_nvm_control_test.sv
module dac_register_nvm_control_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dac_ctrl_pkg::*;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] setup;
    logic [3:0]  halves;
  } row_type;

  logic        clk, rst, wr_en, rd_en, frame_end;
  logic [7:0]  addr;
  logic [15:0] wdata, nvm_rdata, rdata, nvm_wdata;
  logic [9:0]  out_code;
  logic [1:0]  output_power_down_mode, waveform_select;
  logic        ref_enable, waveform_launch, store_busy, update_pending, nvm_we;
  logic [3:0]  gain_halves;
  logic        user_image_check_fail, factory_image_check_fail;
  logic [2:0]  nvm_addr;
  int          error_cnt, samples_checked, cycles;
  row_type     rows [4] = '{
    '{16'h0000, 16'h0000, 4'h3}, '{16'h0004, 16'h0005, 4'h4},
    '{16'h0800, 16'h001A, 4'h6}, '{16'h0FFC, 16'h000F, 4'h8}};

  dac_register_nvm_control u_dut (
    .clk(clk), .rst(rst), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .frame_end(frame_end), .nvm_rdata(nvm_rdata), .rdata(rdata), .out_code(out_code),
    .output_power_down_mode(output_power_down_mode), .ref_enable(ref_enable),
    .gain_halves(gain_halves), .waveform_select(waveform_select),
    .waveform_launch(waveform_launch), .store_busy(store_busy),
    .update_pending(update_pending), .user_image_check_fail(user_image_check_fail),
    .factory_image_check_fail(factory_image_check_fail), .nvm_addr(nvm_addr),
    .nvm_we(nvm_we), .nvm_wdata(nvm_wdata));

  nvm_image_model u_mem (
    .clk(clk), .nvm_addr(nvm_addr), .nvm_we(nvm_we), .nvm_wdata(nvm_wdata),
    .nvm_rdata(nvm_rdata));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      error_cnt++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("Checks made %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Check word: msb first, seed zero, over words lo..hi of the image
  function automatic logic [9:0] crc_of(input int lo, input int hi);
    logic [9:0] c;
    c = CRC_SEED;
    for (int w = lo; w <= hi; w++) begin
      for (int b = 15; b >= 0; b--) begin
        c = {c[8:0], 1'b0} ^ ((c[9] ^ u_mem.mem[w][b]) ? CRC_POLY : 10'h000);
      end
    end
    return c;
  endfunction

  task automatic load_image(input logic [15:0] s, input logic [15:0] c);
    u_mem.mem[0] = s;
    u_mem.mem[1] = 16'h0000;
    u_mem.mem[2] = c;
    u_mem.mem[3] = 16'h0AB0;
    u_mem.mem[4] = 16'h0120;
    u_mem.mem[5] = {6'h00, crc_of(0, 4)};
    u_mem.mem[6] = 16'h1234;
    u_mem.mem[7] = {6'h00, crc_of(6, 6)};
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    wr_en = 1'b1;
    addr  = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(negedge clk);
    rd_en = 1'b1;
    addr  = a;
    @(negedge clk);
    rd_en = 1'b0;
    chk(rdata, exp);
  endtask

  task automatic pulse_end();
    @(negedge clk);
    frame_end = 1'b1;
    @(negedge clk);
    frame_end = 1'b0;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 40 && store_busy !== 1'b0; i++) @(negedge clk);
    chk(16'(store_busy), 16'h0000);
  endtask

  task automatic run_op(input logic [15:0] d);
    wr(ADDR_TRIGGERS, d);
    @(negedge clk);
    chk(16'(store_busy), 16'h0001);
    wait_idle();
  endtask

  // Main sequence: power-on load, table rows, then store, reload and fault cases
  initial begin
    {rst, wr_en, rd_en, frame_end, addr, wdata} = '0;
    rst = 1'b1;
    load_image(16'h400E, 16'h0FFC);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    wait_idle();
    chk(16'(out_code), 16'h03FF);
    chk(16'(output_power_down_mode), 16'h0001);
    chk(16'({ref_enable, waveform_select, gain_halves}), 16'h0056);
    $display("Test power-on load done");
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_OUTPUT_SETUP, rows[i].setup);
      wr(ADDR_OUTPUT_CODE, rows[i].code);
      chk(16'(update_pending), 16'h0001);
      chk(16'(out_code), (i == 0) ? 16'h03FF : 16'(rows[i-1].code[11:2]));
      pulse_end();
      chk(16'(out_code), 16'(rows[i].code[11:2]));
      chk(16'(update_pending), 16'h0000);
      chk(16'(gain_halves), 16'(rows[i].halves));
      chk(16'(ref_enable), 16'(rows[i].setup[2]));
      chk(16'(output_power_down_mode), 16'(rows[i].setup[4:3]));
    end
    rd(ADDR_OUTPUT_CODE, 16'h0FFC);
    rd(8'h40, 16'h0000);
    rd(ADDR_STATUS, 16'h0000);
    $display("Test table rows done");
    wr(ADDR_UPPER_MARGIN, 16'h0ABC);
    wr(ADDR_LOWER_MARGIN, 16'h0123);
    wr(ADDR_TRIGGERS, 16'h0020);
    wr(ADDR_OUTPUT_SETUP, 16'h0000);
    chk(16'(store_busy), 16'h0001);
    wait_idle();
    rd(ADDR_OUTPUT_SETUP, 16'h000F);
    rd(ADDR_UPPER_MARGIN, 16'h0ABC);
    chk(u_mem.mem[0], 16'h000F);
    chk(u_mem.mem[2], 16'h0FFC);
    chk(u_mem.mem[3], 16'h0AB0);
    chk(u_mem.mem[4], 16'h0120);
    chk(u_mem.mem[5], {6'h00, crc_of(0, 4)});
    $display("Test store done");
    wr(ADDR_OUTPUT_CODE, 16'h0000);
    pulse_end();
    run_op(16'h0010);
    chk(16'(out_code), 16'h03FF);
    rd(ADDR_TRIGGERS, 16'h0000);
    u_mem.mem[5] = u_mem.mem[5] ^ 16'h0001;
    run_op(16'h0010);
    chk(16'(user_image_check_fail), 16'h0001);
    chk({out_code, gain_halves, output_power_down_mode}, 16'h000F);
    wr(ADDR_OUTPUT_SETUP, 16'h0002);
    rd(ADDR_OUTPUT_SETUP, 16'h0002);
    rd(ADDR_STATUS, 16'h1000);
    u_mem.mem[5] = u_mem.mem[5] ^ 16'h0001;
    u_mem.mem[7] = u_mem.mem[7] ^ 16'h0001;
    run_op(16'h0010);
    chk(16'(factory_image_check_fail), 16'h0001);
    chk(16'(user_image_check_fail), 16'h0001);
    chk(16'(out_code), 16'h03FF);
    $display("Test reload and check words done");
    u_mem.mem[7] = u_mem.mem[7] ^ 16'h0001;
    wr(ADDR_OUTPUT_CODE, 16'h0004);
    pulse_end();
    run_op(16'h000A);
    chk(16'({user_image_check_fail, factory_image_check_fail}), 16'h0000);
    chk(16'(out_code), 16'h03FF);
    $display("Test soft reset done");
    wr(ADDR_TRIGGERS, 16'h0100);
    chk(16'(waveform_launch), 16'h0001);
    // Code written in the same cycle as the frame end is applied at once
    @(negedge clk);
    {wr_en, frame_end, addr, wdata} = {2'b11, ADDR_OUTPUT_CODE, 16'h0008};
    @(negedge clk);
    {wr_en, frame_end} = 2'b00;
    chk(16'(out_code), 16'h0002);
    chk(16'(update_pending), 16'h0000);
    $display("Test launch and write at frame end done");
    test_done();
  end
endmodule // dac_register_nvm_control_test
